// ===== logic/bef_flag_unit.sv
// event flag latch and interrupt line of the backlight driver
// assumes event strobes and register port are synchronous to SYS_CLK;
// the i2c engine decodes the serial frame and hands over one access

// Functional notes
// [RL1] Fade-done flag bit 5 sets when a fade profile finishes.
// [RL2] Every completed fade-out, dimming end included, sets fade-done.
// [RL3] Short or overload on pump output or sinks sets bit 4.
// [RL4] Thermal shutdown sets bit 3.
// [RL5] Pump output above overvoltage threshold sets bit 2.
// [RL6] Second light sensor comparator trip sets bit 1.
// [RL7] Main light sensor comparator trip sets bit 0.
// [RL8] A flag clears only when software writes one to its bit.
// [RL9] Writing zero or reading the flag register changes no flag.
// [RL10] Fade-done enable bit 5 lets fade completions raise the interrupt.
// [RL11] Short flag raises interrupt only while enable bit 4 is set.
// [RL12] Thermal flag raises interrupt only while enable bit 3 is set.
// [RL13] Overvoltage flag raises interrupt only while enable bit 2 set.
// [RL14] Second sensor flag interrupts only with enable bit 1 set.
// [RL15] Main sensor flag interrupts only with enable bit 0 set.
// [RL16] Cleared enables mask the interrupt; flags still set and read.
// [RL17] Mode one: clear with pending events drops line 50 us, reasserts.
// [RL18] Mode zero: clear with pending events keeps the line asserted.
// [RL19] Interrupt asserts when any flag and its enable are set.
module bef_flag_unit
    import bef_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // event strobes from the protection, fader and comparators
    input wire bef_evt_type EVT,
    // register access from the i2c engine
    input wire bef_req_type REQ,
    output logic [7:0] RDATA,
    output logic RDATA_VALID,
    // interrupt configuration bit held in the mode register
    input wire logic REARM_PULSE_MODE,
    // host interrupt line, low while asserted
    output logic IRQ_N
);

    logic [5:0] flags_reg;
    logic [5:0] flags_next;
    logic [5:0] mask_reg;
    logic [5:0] mask_next;
    logic [5:0] evt_bits;
    logic [5:0] clear_bits;
    logic flags_wr;
    logic mask_wr;
    logic clear_try;
    logic pending;
    logic pending_after;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic rvalid_reg;
    logic rvalid_next;
    bef_irq_state_type state_reg;
    bef_irq_state_type state_next;
    logic irq_n_reg;
    logic irq_n_next;
    logic gap_start;
    logic gap_done;

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    assign evt_bits = EVT;
    assign flags_wr = REQ.wr && (REQ.addr == FLAGS_ADDR);
    assign mask_wr = REQ.wr && (REQ.addr == MASK_ADDR);
    // only ones in the written byte clear anything
    assign clear_bits = flags_wr ? REQ.wdata[5:0] : 6'h00;
    assign clear_try = flags_wr && (clear_bits != 6'h00);

    // ------------------------------------------------------------
    // flags and enables
    // ------------------------------------------------------------
    // set beats clear so an event in the clearing cycle survives
    always_comb
    begin
        flags_next = (flags_reg & ~clear_bits) // see [RL8] see [RL9]
            | evt_bits; // see [RL1] see [RL2] see [RL3] see [RL4]
        // bits 2..0 are set the same way: see [RL5] see [RL6] see [RL7]
        // masking never gates a flag's own setting, see [RL16]
        mask_next = mask_reg;
        if (mask_wr)
        begin
            mask_next = REQ.wdata[5:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            flags_reg <= FLAGS_RESET;
            mask_reg <= MASK_RESET;
        end
        else
        begin
            flags_reg <= flags_next;
            mask_reg <= mask_next;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // reads return state only; they never touch the flags
    always_comb
    begin
        rdata_next = rdata_reg;
        rvalid_next = REQ.rd;
        if (REQ.rd)
        begin
            unique case (REQ.addr)
                FLAGS_ADDR: rdata_next = bef_to_byte(flags_reg); // see [RL9]
                MASK_ADDR: rdata_next = bef_to_byte(mask_reg); // see [RL19]
                default: rdata_next = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rdata_reg <= UNMAPPED_READ;
            rvalid_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign RDATA = rdata_reg;
    assign RDATA_VALID = rvalid_reg;

    // ------------------------------------------------------------
    // interrupt line
    // ------------------------------------------------------------
    // per-bit gating of each flag by its enable
    // see [RL10] see [RL11] see [RL12] see [RL13] see [RL14] see [RL15]
    assign pending = |(flags_reg & mask_reg); // see [RL19]
    // what stays pending once this cycle's clear has landed
    assign pending_after = |(flags_next & mask_next);
    assign gap_start = (state_reg == IRQ_ON) && clear_try
        && REARM_PULSE_MODE && pending_after;

    // state decides the line; gap state forces it high
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            IRQ_IDLE:
            begin
                if (pending_after)
                    state_next = IRQ_ON;
            end
            IRQ_ON:
            begin
                if (!pending_after)
                    state_next = IRQ_IDLE;
                else if (gap_start)
                    state_next = IRQ_GAP; // see [RL17]
                else
                    state_next = IRQ_ON; // see [RL18]
            end
            IRQ_GAP:
            begin
                // events arriving during the gap wait for its end
                if (gap_done)
                    state_next = pending_after ? IRQ_ON : IRQ_IDLE;
            end
            default: state_next = IRQ_IDLE;
        endcase
        irq_n_next = (state_next != IRQ_ON);
    end

    always_ff @(posedge SYS_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            state_reg <= IRQ_IDLE;
            irq_n_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            irq_n_reg <= irq_n_next;
        end
    end

    assign IRQ_N = irq_n_reg;

    // timer for the line drop; a 2000 cycle count sits in its own module
    bef_gap_timer bef_gap_timer_inst (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .start(gap_start),
        .done(gap_done)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_clear_pending;
        (state_reg == IRQ_ON) && clear_try && REARM_PULSE_MODE
            && pending_after;
    endsequence

    sequence s_gap_end_pending;
        (state_reg == IRQ_GAP) && gap_done && pending_after;
    endsequence

    sequence s_clear_hold;
        !IRQ_N && clear_try && !REARM_PULSE_MODE && pending_after;
    endsequence

    sequence s_gap_end_idle;
        (state_reg == IRQ_GAP) && gap_done && !pending_after;
    endsequence

    property p_fade_set;
        @(posedge SYS_CLK) disable iff (!RST_N)
        EVT.fade_done |=> flags_reg[FADE_DONE_BIT];
    endproperty
    a_fade_set: assert property (p_fade_set) // see [RL1] see [RL2]
        else $error("fade done event lost");

    property p_event_set;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (evt_bits != 6'h00) |=>
            ((flags_reg & $past(evt_bits)) == $past(evt_bits));
    endproperty
    a_event_set: assert property (p_event_set) // see [RL3] see [RL7]
        else $error("event did not set its flag");

    property p_w1c;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (flags_wr && evt_bits == 6'h00) |=>
            (flags_reg == ($past(flags_reg) & ~$past(REQ.wdata[5:0])));
    endproperty
    a_w1c: assert property (p_w1c) // see [RL8]
        else $error("write one to clear misbehaved");

    property p_no_write_keeps;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !flags_wr |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg));
    endproperty
    a_no_write_keeps: assert property (p_no_write_keeps) // see [RL9]
        else $error("flag dropped without a clear");

    property p_read_flags;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (REQ.rd && REQ.addr == FLAGS_ADDR) |=>
            RDATA_VALID && RDATA == {2'b00, $past(flags_reg)};
    endproperty
    a_read_flags: assert property (p_read_flags) // see [RL9] see [RL19]
        else $error("flag read returned wrong byte");

    property p_irq_raise;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (pending_after && state_reg != IRQ_GAP && !gap_start) |=> !IRQ_N;
    endproperty
    a_irq_raise: assert property (p_irq_raise) // see [RL10] see [RL15]
        else $error("enabled flag did not raise the line");

    property p_masked_quiet;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (!pending_after) |=> IRQ_N
            ##0 ((flags_reg & $past(evt_bits)) == $past(evt_bits));
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) // see [RL16]
        else $error("masked flag drove the line");

    property p_hold_mode0;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_clear_hold |=> !IRQ_N;
    endproperty
    a_hold_mode0: assert property (p_hold_mode0) // see [RL18]
        else $error("line dropped in hold mode");

    property p_gap_drop;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_clear_pending |=> IRQ_N [*8];
    endproperty
    a_gap_drop: assert property (p_gap_drop) // see [RL17]
        else $error("line did not drop on clear");

    property p_gap_reassert;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_gap_end_pending |=> !IRQ_N;
    endproperty
    a_gap_reassert: assert property (p_gap_reassert) // see [RL17]
        else $error("line not reasserted after gap");

    property p_reserved_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
        RDATA_VALID |-> (RDATA[7:6] == 2'b00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) // see [RL19]
        else $error("reserved bits read nonzero");

    // the line is only ever low while some enabled flag stands
    property p_irq_gated;
        @(posedge SYS_CLK) disable iff (!RST_N)
        !IRQ_N |-> pending;
    endproperty
    a_irq_gated: assert property (p_irq_gated) // see [RL11] see [RL14]
        else $error("line low with no enabled flag");

    property p_mask_keeps_flags;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (mask_wr && evt_bits == 6'h00) |=>
            (flags_reg == $past(flags_reg));
    endproperty
    a_mask_keeps_flags: assert property (p_mask_keeps_flags) // see [RL16]
        else $error("enable write changed a flag");

    property p_mask_write;
        @(posedge SYS_CLK) disable iff (!RST_N)
        mask_wr |=> (mask_reg == $past(REQ.wdata[5:0]));
    endproperty
    a_mask_write: assert property (p_mask_write) // see [RL10]
        else $error("enable write did not land");

    property p_read_mask;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (REQ.rd && REQ.addr == MASK_ADDR) |=>
            RDATA_VALID && RDATA == {2'b00, $past(mask_reg)};
    endproperty
    a_read_mask: assert property (p_read_mask) // see [RL19]
        else $error("enable read returned wrong byte");

    property p_gap_high;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (state_reg == IRQ_GAP) |-> IRQ_N;
    endproperty
    a_gap_high: assert property (p_gap_high) // see [RL17]
        else $error("line low inside the gap");

    property p_gap_exit_idle;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_gap_end_idle |=> IRQ_N && (state_reg == IRQ_IDLE);
    endproperty
    a_gap_exit_idle: assert property (p_gap_exit_idle) // see [RL17]
        else $error("line reasserted with nothing pending");

    property p_valid_pulse;
        @(posedge SYS_CLK) disable iff (!RST_N)
        RDATA_VALID |-> $past(REQ.rd);
    endproperty
    a_valid_pulse: assert property (p_valid_pulse) // see [RL9]
        else $error("read answer without a read");

endmodule

// ===== logic/bef_gap_timer.sv
// one-shot timer for the interrupt line drop
// assumes start is a one-cycle pulse; restarts are ignored while busy

module bef_gap_timer
    import bef_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    output logic done
);

    logic [GAP_CNT_W-1:0] cnt_reg;
    logic [GAP_CNT_W-1:0] cnt_next;
    logic busy_reg;
    logic busy_next;
    int unsigned len_reg;

    // ------------------------------------------------------------
    // countdown
    // ------------------------------------------------------------
    // done is high in the last busy cycle
    assign done = busy_reg && (cnt_reg == '0);

    always_comb
    begin
        cnt_next = cnt_reg;
        busy_next = busy_reg;
        if (start && !busy_reg)
        begin
            cnt_next = GAP_LOAD;
            busy_next = 1'b1;
        end
        else if (done)
        begin
            busy_next = 1'b0;
        end
        else if (busy_reg)
        begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // helper: cycles spent busy so far
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            len_reg <= 0;
        else if (!busy_reg)
            len_reg <= 0;
        else
            len_reg <= len_reg + 1;
    end

    property p_gap_length;
        @(posedge clk) disable iff (!rst_n)
        done |-> (len_reg == GAP_CYCLES - 1);
    endproperty
    a_gap_length: assert property (p_gap_length) // see [RL17]
        else $error("gap length differs from 50 us");

endmodule

// ===== logic/bef_pkg.sv
// constants and carriers for the backlight event flag unit
// assumes one 40 MHz clock and a register port fed by the i2c engine

package bef_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned GAP_TIME_US = 50;
    // line drop on a clear with pending events, in clock cycles
    localparam int unsigned GAP_CYCLES =
        (GAP_TIME_US * CLK_HZ) / 1_000_000;
    localparam int GAP_CNT_W = 11;
    localparam logic [GAP_CNT_W-1:0] GAP_LOAD =
        GAP_CNT_W'(GAP_CYCLES - 1);

    // ------------------------------------------------------------
    // register map and field layout
    // ------------------------------------------------------------
    localparam logic [7:0] FLAGS_ADDR = 8'h02;
    localparam logic [7:0] MASK_ADDR = 8'h03;
    localparam int NUM_EVENTS = 6;
    localparam int SENSOR_A_BIT = 0;
    localparam int SENSOR_B_BIT = 1;
    localparam int OVERVOLTAGE_BIT = 2;
    localparam int OVERTEMP_BIT = 3;
    localparam int SHORT_FAULT_BIT = 4;
    localparam int FADE_DONE_BIT = 5;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;
    localparam logic [1:0] RESERVED_READ = 2'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    // event strobes, bit order equals the flag register layout
    typedef struct packed {
        logic fade_done;
        logic short_fault;
        logic overtemp;
        logic overvoltage;
        logic sensor_b_trip;
        logic sensor_a_trip;
    } bef_evt_type;

    // one register access from the serial front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bef_req_type;

    typedef enum logic [2:0] {
        IRQ_IDLE = 3'b001,
        IRQ_ON = 3'b010,
        IRQ_GAP = 3'b100
    } bef_irq_state_type;

    // widen a six bit register to a byte, reserved bits as zero
    function automatic logic [7:0] bef_to_byte(input logic [5:0] v);
        bef_to_byte = {RESERVED_READ, v};
    endfunction

endpackage

// ===== verification/bef_flag_unit_tb.sv
// self-checking bench for the backlight event flag unit
// assumes the package, the design and the host model are compiled first

module bef_flag_unit_tb
    import bef_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rearm_mode = 1'b0;
    bef_evt_type evt = '0;
    bef_req_type req;
    logic [7:0] rdata;
    logic rdata_valid;
    logic irq_n;
    int failures = 0;
    int check_count = 0;

    // 40 MHz system clock
    always #12.5 sys_clk = ~sys_clk;

    bef_flag_unit bef_flag_unit_inst (
        .SYS_CLK(sys_clk),
        .RST_N(rst_n),
        .EVT(evt),
        .REQ(req),
        .RDATA(rdata),
        .RDATA_VALID(rdata_valid),
        .REARM_PULSE_MODE(rearm_mode),
        .IRQ_N(irq_n)
    );

    bef_host_model bef_host_model_inst (
        .clk(sys_clk),
        .req(req),
        .rdata(rdata),
        .rdata_valid(rdata_valid)
    );

    // ------------------------------------------------------------
    // shared helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic read_chk(input string what, input logic [7:0] a,
        input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        bef_host_model_inst.read_byte(a, d, ok);
        check({what, " valid"}, {15'h0000, ok}, 16'h0001);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask

    // let a register write land, then look at the line
    task automatic irq_chk(input logic exp);
        @(posedge sys_clk);
        #1;
        check("irq_n", {15'h0000, irq_n}, {15'h0000, exp});
    endtask

    task automatic pulse_evt(input logic [5:0] v);
        @(posedge sys_clk);
        #1;
        evt = bef_evt_type'(v);
        @(posedge sys_clk);
        #1;
        evt = '0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bef_host_model_inst.write_byte(a, d);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_reset_and_map();
        irq_chk(1'b1);
        read_chk("flags", FLAGS_ADDR, 8'h00);
        read_chk("mask", MASK_ADDR, 8'h00);
        read_chk("unmapped", 8'h10, UNMAPPED_READ);
        wr(8'h10, 8'hff);
        read_chk("stray mask", MASK_ADDR, 8'h00);
        read_chk("stray flags", FLAGS_ADDR, 8'h00);
        wr(MASK_ADDR, 8'hff);
        read_chk("mask reserved", MASK_ADDR, 8'h3f);
        wr(MASK_ADDR, 8'h00);
    endtask

    // each event alone: latch, mask, enable, keep, clear
    task automatic test_each_event();
        logic [7:0] b;
        for (int i = 0; i < NUM_EVENTS; i++)
        begin
            b = 8'h01 << i;
            pulse_evt(b[5:0]);
            read_chk("set", FLAGS_ADDR, b);
            irq_chk(1'b1);
            wr(MASK_ADDR, ~b & 8'h3f);
            irq_chk(1'b1);
            wr(MASK_ADDR, b);
            irq_chk(1'b0);
            wr(FLAGS_ADDR, 8'h00);
            irq_chk(1'b0);
            read_chk("flag kept", FLAGS_ADDR, b);
            read_chk("flag reread", FLAGS_ADDR, b);
            wr(FLAGS_ADDR, b);
            irq_chk(1'b1);
            read_chk("flag cleared", FLAGS_ADDR, 8'h00);
            wr(MASK_ADDR, 8'h00);
        end
    endtask

    // a fade ending in the very cycle of its clear still counts
    task automatic test_fade_repeat();
        wr(MASK_ADDR, 8'h20);
        pulse_evt(6'h20);
        read_chk("fade set", FLAGS_ADDR, 8'h20);
        irq_chk(1'b0);
        fork
            wr(FLAGS_ADDR, 8'h20);
            pulse_evt(6'h20);
        join
        read_chk("fade again", FLAGS_ADDR, 8'h20);
        irq_chk(1'b0);
        wr(FLAGS_ADDR, 8'h20);
        irq_chk(1'b1);
        wr(MASK_ADDR, 8'h00);
    endtask

    // partial clear with another event pending, line watched per cycle
    task automatic test_rearm(input logic mode);
        int highs;
        logic [15:0] gap_exp;
        highs = 0;
        gap_exp = mode ? 16'(GAP_CYCLES) : 16'h0000;
        rearm_mode = mode;
        wr(MASK_ADDR, 8'h18);
        pulse_evt(6'h18);
        irq_chk(1'b0);
        wr(FLAGS_ADDR, 8'h08);
        // in mode one the line rises at the clear's own edge, so sample before waiting
        for (int n = 0; n < 2500; n++)
        begin
            if (irq_n === 1'b1)
                highs++;
            @(posedge sys_clk);
            #1;
        end
        check("gap cycles", 16'(highs), gap_exp);
        check("irq after", {15'h0000, irq_n}, 16'h0000);
        read_chk("left", FLAGS_ADDR, 8'h10);
        wr(FLAGS_ADDR, 8'h10);
        repeat (4) @(posedge sys_clk);
        irq_chk(1'b1);
        wr(MASK_ADDR, 8'h00);
    endtask

    // the rest cleared inside the gap: the line stays high after it
    task automatic test_gap_clear();
        rearm_mode = 1'b1;
        wr(MASK_ADDR, 8'h18);
        pulse_evt(6'h18);
        irq_chk(1'b0);
        wr(FLAGS_ADDR, 8'h08);
        irq_chk(1'b1);
        wr(FLAGS_ADDR, 8'h10);
        read_chk("gap cleared", FLAGS_ADDR, 8'h00);
        repeat (2100) @(posedge sys_clk);
        irq_chk(1'b1);
        rearm_mode = 1'b0;
        wr(MASK_ADDR, 8'h00);
    endtask

    // reset in mid-run drops every flag and the line
    task automatic test_mid_reset();
        wr(MASK_ADDR, 8'h3f);
        pulse_evt(6'h3f);
        irq_chk(1'b0);
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq_n reset", {15'h0000, irq_n}, 16'h0001);
        rst_n = 1'b1;
        read_chk("flags reset", FLAGS_ADDR, 8'h00);
        read_chk("mask reset", MASK_ADDR, 8'h00);
    endtask

    // ------------------------------------------------------------
    // sequencing and verdict
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        test_reset_and_map();
        test_each_event();
        test_fade_repeat();
        test_rearm(1'b1);
        test_rearm(1'b0);
        test_gap_clear();
        test_mid_reset();
        end_of_test();
    end

    // whole run needs about 8000 cycles; 20000 leaves ample margin
    initial
    begin
        #500_000;
        failures++;
        end_of_test();
    end
endmodule

// ===== verification/bef_host_model.sv
// host processor model issuing single byte register accesses
// assumes the unit samples requests on the rising edge of clk

module bef_host_model
    import bef_pkg::*;
(
    // clock
    input wire logic clk,
    // register port toward the unit
    output bef_req_type req,
    input wire logic [7:0] rdata,
    input wire logic rdata_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    // ------------------------------------------------------------
    // bus idle handling
    // ------------------------------------------------------------
    // idle lines flip so a stale value is never mistaken for data
    task automatic release_bus();
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask

    initial
    begin
        req = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 8'hff};
    end

    // ------------------------------------------------------------
    // accesses
    // ------------------------------------------------------------
    // flags are cleared only by writing ones to them
    task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        #1;
        release_bus();
    endtask

    // answer stands one cycle only: taken in the cycle right after
    // the edge that took the request, never later
    task automatic read_byte(input logic [7:0] a, output logic [7:0] d,
        output logic ok);
        @(posedge clk);
        #1;
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~req.wdata};
        @(posedge clk);
        #1;
        ok = rdata_valid;
        d = rdata;
        release_bus();
    endtask
endmodule
